// >>> design/nfh_ctrl.sv
// Purpose: host controller driving a nand flash for erase, reset and features
// Assumes: software port of own registers; device pins sampled through nfh_sync
// Notes: strobes are decoded from state, data bytes come from flip-flops
// Notes on behaviour
// - erase setup 60h then three row address bytes; page bits ignored by device
// - final pair of a two-plane erase is 60h then D0h
// - next queue command only once ready/busy shows ready again
// - plane select bit low on first address input, high on second
// - both planes of a two-plane operation do the same kind of work
// - feature commands carry one address byte and four parameter bytes
// - get features: EEh, address, busy wait, then read bytes by read strobe
// - after a status poll in get features, 00h restores data output
// - set features: EFh, address, four bytes, then busy while stored
// - write protect stays stable from first command until ready
// - single erase is setup, three address bytes, confirm, then busy
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module nfh_ctrl (
  input wire logic clk, // 250 MHz clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic ce_n, // chip enable, active low
  output logic cle, // command latch enable
  output logic ale, // address latch enable
  output logic we_n, // write strobe, active low
  output logic read_strobe_n, // read strobe, active low
  output logic wp_n, // write protect, active low
  output logic [7:0] io_out, // data bus out
  output logic io_oe, // data bus output enable
  input wire logic [7:0] io_in, // data bus in
  input wire logic ready_busy_n // ready high, busy low
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_PREP, ST_NEXT, ST_GAP, ST_WLOW, ST_WHIGH,
    ST_RLOW, ST_RHIGH, ST_SETTLE, ST_BUSY
  } nfh_state_t;

  localparam logic [7:0] WL = 8'(nfh_pkg::WE_LOW_CYC);
  localparam logic [7:0] WH = 8'(nfh_pkg::WE_HIGH_CYC);
  localparam logic [7:0] ADL = 8'(nfh_pkg::ADL_CYC);
  localparam logic [7:0] RL = 8'(nfh_pkg::RE_LOW_CYC);
  localparam logic [7:0] RH = 8'(nfh_pkg::RE_HIGH_CYC);
  localparam logic [7:0] SETTLE = 8'(nfh_pkg::BUSY_SETTLE_CYC);
  localparam logic [7:0] PSETUP = 8'(nfh_pkg::PROT_SETUP_CYC);

  nfh_state_t st, next_st;
  logic [3:0] step, next_step;
  logic [7:0] cnt, next_cnt;
  logic [7:0] ww_cnt;
  logic [2:0] op;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [23:0] row0;
  logic [23:0] row1;
  logic [7:0] faddr;
  logic [31:0] fdata;
  logic [31:0] feat_rd;
  logic fr_valid;
  logic [7:0] status_byte;
  logic refused;
  logic fail;
  logic rst_ok;
  logic prot;
  logic [1:0] drive;
  logic [1:0] pulldn;
  logic [2:0] step_kind;
  logic [3:0] step_src;
  logic [7:0] step_byte;
  logic [7:0] io_s;
  logic rb_s;
  logic we_d;
  logic [3:0] rise_cnt;

  nfh_sync #(.WIDTH(9)) u_sync (
    .clk(clk),
    .srst(srst),
    .din({ready_busy_n, io_in}),
    .dout({rb_s, io_s})
  );

  // software port decode
  wire ctrl_wr = wr && (addr == nfh_pkg::REG_CTRL);
  wire [2:0] req_op = wdata[2:0];
  wire req_erase = (req_op == nfh_pkg::OP_ERASE) || (req_op == nfh_pkg::OP_ERASE2);
  wire feat_ok = (faddr == nfh_pkg::FEAT_DRIVE) || (faddr == nfh_pkg::FEAT_PULLDN);
  wire gated = prot && req_erase;
  wire bad_feat = (req_op == nfh_pkg::OP_SETF) && !feat_ok;
  wire go_req = ctrl_wr && (req_op != 3'h0);
  wire go = go_req && (st == ST_IDLE) && !gated && !bad_feat;
  wire is_two = (op == nfh_pkg::OP_ERASE2);
  wire ends = (cnt == 8'h01);
  wire we_rise = we_n && !we_d;

  // plane select forced per address input of a two-plane erase; block bits of the first are don't care
  wire [23:0] row0_x = {row0[23:nfh_pkg::PLANE_BIT+1], 1'b0, row0[nfh_pkg::PLANE_BIT-1:0]};
  wire [23:0] row1_x = is_two ?
      {row1[23:nfh_pkg::PLANE_BIT+1], 1'b1, row1[nfh_pkg::PLANE_BIT-1:0]} : row1;
  // reserved bits and bytes of a strength parameter always go out as zero
  wire [7:0] set_byte = (wr_idx == 2'h0) ? (fdata[7:0] & nfh_pkg::STRENGTH_MASK) : 8'h00;
  wire [7:0] reset_sr = prot ? nfh_pkg::SR_AFTER_RESET_WP_LO : nfh_pkg::SR_AFTER_RESET_WP_HI;

  // per-operation pin sequences
  always_comb begin
    {step_kind, step_src, step_byte} = {nfh_pkg::K_END, nfh_pkg::S_CONST, 8'h00};
    unique case (op)
      nfh_pkg::OP_ERASE: begin
        case (step)
          4'd0: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_ERASE};
          4'd1: {step_kind, step_src, step_byte} = {nfh_pkg::K_ADR, nfh_pkg::S_R1B0, row1_x[7:0]};
          4'd2: {step_kind, step_byte} = {nfh_pkg::K_ADR, row1_x[15:8]};
          4'd3: {step_kind, step_byte} = {nfh_pkg::K_ADR, row1_x[23:16]};
          4'd4: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_CONFIRM};
          4'd5: step_kind = nfh_pkg::K_BSY;
          4'd6: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_STATUS};
          4'd7: {step_kind, step_src} = {nfh_pkg::K_RD, nfh_pkg::S_SR};
          default: step_kind = nfh_pkg::K_END;
        endcase
      end
      nfh_pkg::OP_ERASE2: begin
        case (step) // erase on both planes only
          4'd0: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_ERASE};
          4'd1: {step_kind, step_src, step_byte} = {nfh_pkg::K_ADR, nfh_pkg::S_R0B0, row0_x[7:0]};
          4'd2: {step_kind, step_byte} = {nfh_pkg::K_ADR, row0_x[15:8]};
          4'd3: {step_kind, step_byte} = {nfh_pkg::K_ADR, row0_x[23:16]};
          4'd4: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_QUEUE};
          4'd5: step_kind = nfh_pkg::K_BSY;
          4'd6: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_ERASE};
          4'd7: {step_kind, step_src, step_byte} = {nfh_pkg::K_ADR, nfh_pkg::S_R1B0, row1_x[7:0]};
          4'd8: {step_kind, step_byte} = {nfh_pkg::K_ADR, row1_x[15:8]};
          4'd9: {step_kind, step_byte} = {nfh_pkg::K_ADR, row1_x[23:16]};
          4'd10: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_CONFIRM};
          4'd11: step_kind = nfh_pkg::K_BSY;
          4'd12: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_STATUS};
          4'd13: {step_kind, step_src} = {nfh_pkg::K_RD, nfh_pkg::S_SR};
          default: step_kind = nfh_pkg::K_END;
        endcase
      end
      nfh_pkg::OP_RESET: begin
        case (step)
          4'd0: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_RESET};
          4'd1: step_kind = nfh_pkg::K_BSY;
          4'd2: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_STATUS};
          4'd3: {step_kind, step_src} = {nfh_pkg::K_RD, nfh_pkg::S_SR};
          default: step_kind = nfh_pkg::K_END;
        endcase
      end
      nfh_pkg::OP_GETF: begin
        case (step)
          4'd0: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_GETF};
          4'd1: {step_kind, step_byte} = {nfh_pkg::K_ADR, faddr};
          4'd2: step_kind = nfh_pkg::K_BSY;
          // data output mode restored in case software polled status meanwhile
          4'd3: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_READ};
          4'd4, 4'd5, 4'd6, 4'd7: {step_kind, step_src} = {nfh_pkg::K_RD, nfh_pkg::S_FRD};
          default: step_kind = nfh_pkg::K_END;
        endcase
      end
      nfh_pkg::OP_SETF: begin
        case (step)
          4'd0: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_SETF};
          4'd1: {step_kind, step_byte} = {nfh_pkg::K_ADR, faddr};
          4'd2, 4'd3, 4'd4, 4'd5: {step_kind, step_src, step_byte} =
              {nfh_pkg::K_WR, nfh_pkg::S_FDATA, set_byte};
          4'd6: step_kind = nfh_pkg::K_BSY;
          default: step_kind = nfh_pkg::K_END;
        endcase
      end
      nfh_pkg::OP_STAT: begin
        case (step)
          4'd0: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_STATUS};
          4'd1: {step_kind, step_src} = {nfh_pkg::K_RD, nfh_pkg::S_SR};
          default: step_kind = nfh_pkg::K_END;
        endcase
      end
      nfh_pkg::OP_ESTAT: begin
        case (step) // names the failing plane
          4'd0: {step_kind, step_byte} = {nfh_pkg::K_CMD, nfh_pkg::CMD_ESTATUS};
          4'd1: {step_kind, step_byte} = {nfh_pkg::K_ADR, row1_x[7:0]};
          4'd2: {step_kind, step_byte} = {nfh_pkg::K_ADR, row1_x[15:8]};
          4'd3: {step_kind, step_byte} = {nfh_pkg::K_ADR, row1_x[23:16]};
          4'd4: {step_kind, step_src} = {nfh_pkg::K_RD, nfh_pkg::S_SR};
          default: step_kind = nfh_pkg::K_END;
        endcase
      end
      default: step_kind = nfh_pkg::K_END;
    endcase
  end

  // sequencer
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_step = step;
    unique case (st)
      ST_IDLE: begin
        if (go) begin
          next_st = ST_PREP;
          next_step = 4'h0;
        end
      end
      ST_PREP: if (ww_cnt == 8'h00) next_st = ST_NEXT;
      ST_NEXT: begin
        if (step_kind == nfh_pkg::K_CMD || step_kind == nfh_pkg::K_ADR) begin
          next_st = ST_WLOW;
          next_cnt = WL;
        end else if (step_kind == nfh_pkg::K_WR) begin
          next_st = (wr_idx == 2'h0) ? ST_GAP : ST_WLOW;
          next_cnt = (wr_idx == 2'h0) ? ADL : WL;
        end else if (step_kind == nfh_pkg::K_RD) begin
          next_st = ST_RLOW;
          next_cnt = RL;
        end else if (step_kind == nfh_pkg::K_BSY) begin
          next_st = ST_SETTLE;
          next_cnt = SETTLE;
        end else begin
          next_st = ST_IDLE;
        end
      end
      ST_GAP: begin
        next_cnt = ends ? WL : cnt - 8'h01;
        if (ends) next_st = ST_WLOW;
      end
      ST_WLOW: begin
        next_cnt = ends ? WH : cnt - 8'h01;
        if (ends) next_st = ST_WHIGH;
      end
      ST_RLOW: begin
        next_cnt = ends ? RH : cnt - 8'h01;
        if (ends) next_st = ST_RHIGH;
      end
      ST_WHIGH, ST_RHIGH: begin
        next_cnt = cnt - 8'h01;
        if (ends) begin
          next_st = ST_NEXT;
          next_step = step + 4'h1;
        end
      end
      ST_SETTLE: begin
        next_cnt = cnt - 8'h01;
        if (ends) next_st = ST_BUSY;
      end
      ST_BUSY: begin
        if (rb_s) begin
          next_st = ST_NEXT;
          next_step = step + 4'h1;
        end
      end
    endcase
  end

  // pin strobes; decoded, so a board may want them retimed
  assign ce_n = (st == ST_IDLE);
  assign cle = (st == ST_WLOW || st == ST_WHIGH) && (step_kind == nfh_pkg::K_CMD);
  assign ale = (st == ST_WLOW || st == ST_WHIGH) && (step_kind == nfh_pkg::K_ADR);
  assign we_n = (st != ST_WLOW);
  assign read_strobe_n = (st != ST_RLOW);
  assign io_oe = (st == ST_WLOW || st == ST_WHIGH);
  assign wp_n = !prot;

  wire rd_take = (st == ST_RLOW) && ends;
  wire at_end = (st == ST_NEXT) && (step_kind == nfh_pkg::K_END);

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= ST_IDLE;
      step <= 4'h0;
      cnt <= 8'h00;
      io_out <= 8'h00;
      we_d <= 1'b1;
    end else begin
      st <= next_st;
      step <= next_step;
      cnt <= next_cnt;
      we_d <= we_n;
      if (next_st == ST_WLOW && st != ST_WLOW) io_out <= step_byte;
    end
  end

  // operation bookkeeping and results
  always_ff @(posedge clk) begin
    if (srst) begin
      op <= 3'h0;
      wr_idx <= 2'h0;
      rd_idx <= 2'h0;
      feat_rd <= 32'h0000_0000;
      fr_valid <= 1'b0;
      status_byte <= 8'h00;
      fail <= 1'b0;
      rst_ok <= 1'b0;
      refused <= 1'b0;
      drive <= nfh_pkg::STRENGTH_FULL;
      pulldn <= nfh_pkg::STRENGTH_FULL;
    end else begin
      if (go) begin
        op <= req_op;
        wr_idx <= 2'h0;
        rd_idx <= 2'h0;
        refused <= 1'b0;
        if (req_op == nfh_pkg::OP_RESET || req_op == nfh_pkg::OP_GETF) fr_valid <= 1'b0;
      end else if (go_req) begin
        refused <= 1'b1;
      end
      if (st == ST_WHIGH && ends && step_kind == nfh_pkg::K_WR) wr_idx <= wr_idx + 2'h1;
      if (rd_take && step_src == nfh_pkg::S_SR) begin
        status_byte <= io_s;
        if (op == nfh_pkg::OP_ERASE || op == nfh_pkg::OP_ERASE2) begin
          fail <= io_s[nfh_pkg::SR_READY_BIT] && io_s[nfh_pkg::SR_FAIL_BIT];
        end
        if (op == nfh_pkg::OP_RESET) rst_ok <= (io_s == reset_sr);
      end
      if (rd_take && step_src == nfh_pkg::S_FRD) begin
        feat_rd[8*rd_idx +: 8] <= io_s; // first byte in bits 7:0
        rd_idx <= rd_idx + 2'h1;
      end
      if (at_end && op == nfh_pkg::OP_GETF) fr_valid <= 1'b1;
      // shadows follow set features only; a reset command leaves them
      if (at_end && op == nfh_pkg::OP_SETF && faddr == nfh_pkg::FEAT_DRIVE) drive <= fdata[1:0];
      if (at_end && op == nfh_pkg::OP_SETF && faddr == nfh_pkg::FEAT_PULLDN) pulldn <= fdata[1:0];
    end
  end

  // software registers; protect changes only while idle
  wire prot_wr = wr && (addr == nfh_pkg::REG_PROT) && (st == ST_IDLE);

  always_ff @(posedge clk) begin
    if (srst) begin
      row0 <= 24'h00_0000;
      row1 <= 24'h00_0000;
      faddr <= 8'h00;
      fdata <= 32'h0000_0000;
      prot <= nfh_pkg::PROT_RESET;
      ww_cnt <= 8'h00;
    end else begin
      if (wr && addr == nfh_pkg::REG_ROW0) row0 <= wdata[23:0];
      if (wr && addr == nfh_pkg::REG_ROW1) row1 <= wdata[23:0];
      if (wr && addr == nfh_pkg::REG_FADDR) faddr <= wdata[7:0];
      if (wr && addr == nfh_pkg::REG_FDATA) fdata <= wdata;
      if (prot_wr) prot <= wdata[0];
      // first command waits out the protect setup time after any change
      if (prot_wr && wdata[0] != prot) ww_cnt <= PSETUP;
      else if (ww_cnt != 8'h00) ww_cnt <= ww_cnt - 8'h01;
    end
  end

  wire busy = (st != ST_IDLE);
  wire [31:0] stat_word = {15'h0000, rb_s, status_byte, 3'h0, fr_valid, rst_ok, fail, refused, busy};
  wire [31:0] rd_mux =
      (addr == nfh_pkg::REG_CTRL) ? {29'h0000_0000, op} :
      (addr == nfh_pkg::REG_ROW0) ? {8'h00, row0} :
      (addr == nfh_pkg::REG_ROW1) ? {8'h00, row1} :
      (addr == nfh_pkg::REG_FADDR) ? {24'h00_0000, faddr} :
      (addr == nfh_pkg::REG_FDATA) ? fdata :
      (addr == nfh_pkg::REG_FREAD) ? feat_rd :
      (addr == nfh_pkg::REG_STAT) ? stat_word :
      (addr == nfh_pkg::REG_PROT) ? {31'h0000_0000, prot} :
      (addr == nfh_pkg::REG_DRIVE) ? {30'h0000_0000, drive} :
      (addr == nfh_pkg::REG_PULLDN) ? {30'h0000_0000, pulldn} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) rdata <= 32'h0000_0000;
    else if (rd) rdata <= rd_mux;
  end

  // helper: strobe rises since chip enable fell
  always_ff @(posedge clk) begin
    if (srst || st == ST_IDLE) rise_cnt <= 4'h0;
    else if (we_rise) rise_cnt <= rise_cnt + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  erase_addr_a:
  assert property (($rose(we_n) && cle && io_out == nfh_pkg::CMD_ERASE)
      |-> ##[1:40] ($rose(we_n) && ale))
    else $error("erase setup not followed by an address byte");
  plane_bit_a:
  assert property ((st == ST_WLOW && is_two && (step_src == nfh_pkg::S_R0B0 ||
      step_src == nfh_pkg::S_R1B0)) |-> io_out[nfh_pkg::PLANE_BIT] == (step_src == nfh_pkg::S_R1B0))
    else $error("plane select bit wrong");
  busy_hold_a:
  assert property ((st == ST_BUSY && !rb_s) |=> (st == ST_BUSY && step == $past(step)))
    else $error("left busy wait while device busy");
  prot_gate_a:
  assert property ((go_req && gated && st == ST_IDLE) |=> (st == ST_IDLE && refused))
    else $error("protected erase was started");
  wp_stable_a:
  assert property ((st != ST_IDLE && $past(st) != ST_IDLE) |-> $stable(wp_n))
    else $error("write protect moved during an operation");
  feat_mask_a:
  assert property ((st == ST_WLOW && step_kind == nfh_pkg::K_WR)
      |-> (io_out & ((wr_idx == 2'h0) ? 8'hFC : 8'hFF)) == 8'h00)
    else $error("reserved feature bits not zero");
  set_count_a:
  assert property ((op == nfh_pkg::OP_SETF && st == ST_SETTLE) |-> rise_cnt == 4'h6)
    else $error("set features did not send command, address and four bytes");
  get_reread_a:
  assert property ((op == nfh_pkg::OP_GETF && st == ST_RLOW) |-> rise_cnt == 4'h3)
    else $error("feature bytes read without the read command");
  reset_keep_a:
  assert property ((op == nfh_pkg::OP_RESET && busy) |=> ($stable(drive) && $stable(pulldn)))
    else $error("reset command changed feature shadows");
endmodule : nfh_ctrl

// >>> design/nfh_pkg.sv
// Purpose: shared constants of the nand flash host controller
// Assumes: 250 MHz clock, x8 device, three row address cycles
// Notes: byte addresses of the software registers are word aligned
package nfh_pkg;
  // software register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ROW0 = 8'h04;
  localparam logic [7:0] REG_ROW1 = 8'h08;
  localparam logic [7:0] REG_FADDR = 8'h0C;
  localparam logic [7:0] REG_FDATA = 8'h10;
  localparam logic [7:0] REG_FREAD = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam logic [7:0] REG_PROT = 8'h1C;
  localparam logic [7:0] REG_DRIVE = 8'h20;
  localparam logic [7:0] REG_PULLDN = 8'h24;
  // operation codes written to CTRL[2:0]
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_ERASE2 = 3'h2;
  localparam logic [2:0] OP_RESET = 3'h3;
  localparam logic [2:0] OP_GETF = 3'h4;
  localparam logic [2:0] OP_SETF = 3'h5;
  localparam logic [2:0] OP_STAT = 3'h6;
  localparam logic [2:0] OP_ESTAT = 3'h7;
  // device command bytes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_QUEUE = 8'hD1;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ESTATUS = 8'h78;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_GETF = 8'hEE;
  localparam logic [7:0] CMD_SETF = 8'hEF;
  // device feature addresses and fields
  localparam logic [7:0] FEAT_DRIVE = 8'h80;
  localparam logic [7:0] FEAT_PULLDN = 8'h81;
  localparam logic [7:0] STRENGTH_MASK = 8'h03;
  localparam logic [1:0] STRENGTH_FULL = 2'h0;
  localparam logic [7:0] SR_AFTER_RESET_WP_HI = 8'hE0;
  localparam logic [7:0] SR_AFTER_RESET_WP_LO = 8'h60;
  localparam int SR_FAIL_BIT = 0;
  localparam int SR_READY_BIT = 6;
  localparam int PLANE_BIT = 6; // plane select within first row byte
  localparam logic PROT_RESET = 1'b1;
  // step kinds of the pin sequencer
  localparam logic [2:0] K_END = 3'h0;
  localparam logic [2:0] K_CMD = 3'h1;
  localparam logic [2:0] K_ADR = 3'h2;
  localparam logic [2:0] K_WR = 3'h3;
  localparam logic [2:0] K_RD = 3'h4;
  localparam logic [2:0] K_BSY = 3'h5;
  // byte sources of a step
  localparam logic [3:0] S_CONST = 4'h0;
  localparam logic [3:0] S_R0B0 = 4'h1;
  localparam logic [3:0] S_R1B0 = 4'h2;
  localparam logic [3:0] S_FDATA = 4'h3;
  localparam logic [3:0] S_SR = 4'h4;
  localparam logic [3:0] S_FRD = 4'h5;
  // timing, least times in ns, rounded up to cycles
  localparam int CLK_NS = 4;
  localparam int WE_LOW_NS = 12;
  localparam int WE_HIGH_NS = 10;
  localparam int ADL_NS = 70;
  localparam int PROT_SETUP_NS = 100;
  localparam int RE_LOW_NS = 25;
  localparam int RE_HIGH_NS = 15;
  localparam int BUSY_SETTLE_NS = 100;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADL_CYC = (ADL_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_SETUP_CYC = (PROT_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RE_LOW_CYC = (RE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RE_HIGH_CYC = (RE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage : nfh_pkg

// >>> design/nfh_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes: a bit changes only once stages two and three agree
`timescale 1ns/10ps
module nfh_sync #(
  parameter int unsigned WIDTH = 1 // bits synchronised
) (
  input wire logic clk, // clock
  input wire logic srst, // synchronous reset
  input wire logic [WIDTH-1:0] din, // asynchronous inputs
  output logic [WIDTH-1:0] dout // filtered, synchronous
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire [WIDTH-1:0] next_dout = (s2 & s3) | (dout & (s2 | s3));

  if (WIDTH < 1) begin : g_chk
    $error("nfh_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : nfh_sync

// >>> tb/nfh_dev.sv
// Purpose: behavioural flash device facing the host controller
// Assumes: busy periods shortened to BUSY_NS
// Notes: released bus shows inverse of last byte
`timescale 1ns/10ps
module nfh_dev #(
  parameter int BUSY_NS = 300 // shortened busy time
) (
  input wire logic ce_n, // chip enable
  input wire logic cle, // command latch
  input wire logic ale, // address latch
  input wire logic we_n, // write strobe
  input wire logic read_strobe_n, // read strobe
  input wire logic wp_n, // write protect
  input wire logic [7:0] io_out, // host bus
  output logic [7:0] io_in, // device bus
  output logic ready_busy_n // ready high
);
  logic [7:0] cmd = 8'h00;
  logic [7:0] fa = 8'h00;
  logic [7:0] sr = 8'hE0;
  logic [7:0] dout = 8'h00;
  logic [7:0] p [4];
  logic [1:0] str [2] = '{2'h0, 2'h0}; // power-on full strength
  int n = 0;
  int k = 0;
  initial ready_busy_n = 1'b1;
  task automatic busy();
    sr[6:5] = 2'b00;
    ready_busy_n = 1'b0; // pin follows bit 6
    #BUSY_NS;
    sr = {wp_n, 7'h60}; // pass, ready
    ready_busy_n = 1'b1;
  endtask : busy
  always @(posedge we_n) if (!ce_n && cle) begin
    cmd = io_out; // any command leaves feature mode
    n = 0;
    k = 0;
    if ((io_out == 8'hD0 || io_out == 8'hD1) && wp_n) busy();
    if (io_out == 8'hFF) busy(); // features kept
  end else if (!ce_n && ale) begin
    fa = io_out; // row bytes ignored
    if (cmd == 8'hEE) begin
      p = '{(io_out[7:1] == 7'h40) ? {6'h0, str[io_out[0]]} : 8'h00, 8'h00, 8'h00, 8'h00};
      busy();
    end
  end else if (!ce_n && cmd == 8'hEF) begin
    p[n] = io_out;
    n++;
    if (n == 4 && fa[7:1] == 7'h40) str[fa[0]] = p[0][1:0];
    if (n == 4) busy();
  end
  always @(negedge read_strobe_n) begin
    dout = (cmd == 8'h70 || cmd == 8'h78) ? sr : p[k[1:0]];
    k++;
  end
  assign io_in = read_strobe_n ? ~dout : dout;
endmodule : nfh_dev

// >>> tb/nfh_ctrl_tb.sv
// Purpose: register-level tests of the flash host controller
// Assumes: device model on the pins
// Notes: expected values from the register map
`timescale 1ns/10ps
module nfh_ctrl_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe, ready_busy_n;
  logic [7:0] io_out, io_in;
  int miscompares = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  nfh_ctrl dut_u (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .ce_n, .cle, .ale, .we_n,
    .read_strobe_n, .wp_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  nfh_dev dev_u (.ce_n, .cle, .ale, .we_n, .read_strobe_n, .wp_n, .io_out, .io_in, .ready_busy_n);
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rreg(a, d);
    n_checks++;
    if ((d & m) !== e) begin
      miscompares++;
      $display("Error %0t: reg %h got %h exp %h", $time, a, d, e);
    end
  endtask : chk
  task automatic op(input logic [2:0] o);
    logic [31:0] d;
    wreg(nfh_pkg::REG_CTRL, {29'h0, o});
    d = 32'h1;
    for (int i = 0; i < 3000 && d[0] !== 1'b0; i++) rreg(nfh_pkg::REG_STAT, d);
  endtask : op
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    chk(nfh_pkg::REG_DRIVE, 32'h3, 32'h0);
    chk(8'h3C, 32'hFFFFFFFF, 32'h0);
    op(nfh_pkg::OP_ERASE);
    chk(nfh_pkg::REG_STAT, 32'h3, 32'h2); // protected erase refused
    wreg(nfh_pkg::REG_PROT, 32'h0);
    wreg(nfh_pkg::REG_ROW0, 32'h0000C5);
    wreg(nfh_pkg::REG_ROW1, 32'h000183);
    op(nfh_pkg::OP_ERASE);
    chk(nfh_pkg::REG_STAT, 32'hFF07, 32'hE000);
    op(nfh_pkg::OP_ERASE2);
    chk(nfh_pkg::REG_STAT, 32'hFF07, 32'hE000);
    $display("test erase done");
    wreg(nfh_pkg::REG_FADDR, 32'h80);
    wreg(nfh_pkg::REG_FDATA, 32'h2);
    op(nfh_pkg::OP_SETF);
    chk(nfh_pkg::REG_DRIVE, 32'h3, 32'h2);
    wreg(nfh_pkg::REG_FADDR, 32'h81);
    wreg(nfh_pkg::REG_FDATA, 32'hFF);
    op(nfh_pkg::OP_SETF);
    op(nfh_pkg::OP_RESET);
    chk(nfh_pkg::REG_STAT, 32'hFF0B, 32'hE008);
    chk(nfh_pkg::REG_PULLDN, 32'h3, 32'h3);
    op(nfh_pkg::OP_GETF);
    chk(nfh_pkg::REG_FREAD, 32'hFFFFFFFF, 32'h3);
    wreg(nfh_pkg::REG_FADDR, 32'h80);
    op(nfh_pkg::OP_GETF);
    chk(nfh_pkg::REG_FREAD, 32'hFFFFFFFF, 32'h2);
    wreg(nfh_pkg::REG_FADDR, 32'h82);
    op(nfh_pkg::OP_SETF);
    chk(nfh_pkg::REG_STAT, 32'h3, 32'h2);
    op(nfh_pkg::OP_STAT);
    chk(nfh_pkg::REG_STAT, 32'hFF03, 32'hE000);
    op(nfh_pkg::OP_ESTAT);
    chk(nfh_pkg::REG_STAT, 32'hFF03, 32'hE000);
    $display("test features done");
    wreg(nfh_pkg::REG_PROT, 32'h1);
    op(nfh_pkg::OP_RESET);
    chk(nfh_pkg::REG_STAT, 32'hFF0B, 32'h6008);
    $display("test reset done");
    close_out();
  end
endmodule : nfh_ctrl_tb
